// *** bench/sbr_gap_ctrl_bench.sv ***
// self-checking bench for the bus-reset and gap-count block
`timescale 1ns/1ps
module sbr_gap_ctrl_bench;
	reg c = 0, n = 0, w = 0, x = 0, t = 0, k = 0;
	reg [7:0] d = 0, v = 8'h4b;
	wire q, b, f;
	wire [7:0] r;
	wire [5:0] g;
	int bad_count = 0, n_tests = 0;
	sbr_gap_ctrl u_dut(.core_clk_i(c), .nrst_i(n), .reg1_wr_i(w), .reg1_wdata_i(d), .cfg_rx_i(x), .cfg_tx_i(t),
		.cfg_rhf_i(d[7]), .cfg_gap_i(d[5:0]), .bus_reset_i(b), .reg1_rdata_o(r), .gap_count_o(g),
		.root_holdoff_flag_o(f), .bus_reset_req_o(q));
	sbr_node_model u_node(.core_clk_i(c), .req_i(q), .tx_i(t), .conn_i(k), .rst_o(b));
	function [7:0] nx(input [7:0] a); nx = {a[6:0], ^(a & 8'hb8)}; endfunction
	task chk(input [6:0] e);
		n_tests++;
		if ({f, g} !== e) begin bad_count++; $display("[FAIL] state exp %h got %h", e, {f, g}); end
	endtask
	task chk_rd(input [7:0] e);
		n_tests++;
		if (r !== e) begin bad_count++; $display("[FAIL] readback exp %h got %h", e, r); end
	endtask
	task s(input [7:0] a, input [3:0] m);
		@(negedge c) {k, t, x, w} <= m;
		d <= a;
		@(negedge c) {k, t, x, w} <= 4'h0;
		repeat (3) @(negedge c);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial forever #10 c = ~c;
	initial begin #100000 bad_count++; complete_run; end
	initial begin
		repeat (16) @(negedge c);
		n = 1;
		chk(7'h3f);
		repeat (6) begin
			v = nx(v);
			s(v | 8'h40, 4'h1); chk({v[7], v[5:0]});
			s(8'h0, 4'h8); chk({v[7], v[5:0]});
			s(8'h0, 4'h8); chk({v[7], 6'h3f});
			v = nx(v);
			s(v, 4'h4); chk_rd({v[7], 1'b0, v[5:0]});
			s(r | 8'h40, 4'h1); chk({v[7], v[5:0]});
			s({v[7], 7'h7f}, 4'h1); chk({v[7], 6'h3f});
			v = nx(v);
			s(v, 4'h2); chk({v[7], v[5:0]});
		end
		@(negedge c) k <= 1;
		repeat (3) @(negedge c);
		k <= 0;
		repeat (3) @(negedge c); chk({v[7], 6'h3f});
		// reset in mid-run brings back the reset state and a cleared counter
		@(negedge c) n = 0;
		@(negedge c) n = 1;
		chk(7'h3f);
		chk_rd(8'h3f);
		s(v | 8'h40, 4'h1); chk({v[7], v[5:0]});
		complete_run;
	end
endmodule // sbr_gap_ctrl_bench

// *** bench/sbr_gap_ctrl_monitor.sv ***
// port assertions for the bus-reset and gap-count block
`timescale 1ns/1ps
module sbr_gap_ctrl_monitor(input wire core_clk_i, nrst_i, reg1_wr_i, cfg_rx_i, cfg_tx_i, cfg_rhf_i, bus_reset_i,
	root_holdoff_flag_o, bus_reset_req_o, input wire [7:0] reg1_wdata_i, reg1_rdata_o,
	input wire [5:0] cfg_gap_i, gap_count_o);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	wire rq = reg1_wr_i & reg1_wdata_i[6];
	wire ld = reg1_wr_i | cfg_rx_i | cfg_tx_i;
	wire [6:0] st = {root_holdoff_flag_o, gap_count_o};
	sequence s_rq; rq; endsequence
	sequence s_rs; bus_reset_i & !ld; endsequence
	a_req_set: assert property (s_rq |=> bus_reset_req_o) else $error("req");
	a_req_none: assert property (!rq |=> !bus_reset_req_o) else $error("req");
	a_wr_load: assert property (reg1_wr_i |=> st == $past({reg1_wdata_i[7], reg1_wdata_i[5:0]})) else $error("wr");
	a_cfg_load: assert property (!reg1_wr_i & ld |=> st == $past({cfg_rhf_i, cfg_gap_i})) else $error("cfg");
	a_tx_read: assert property (!reg1_wr_i & cfg_tx_i |=> reg1_rdata_o[5:0] == $past(cfg_gap_i)) else $error("rd");
	a_force_max: assert property (s_rs [*3] |=> gap_count_o == 6'h3f) else $error("max");
	a_local_keep: assert property (s_rq ##1 !ld ##1 s_rs |=> gap_count_o == $past(reg1_wdata_i[5:0], 3)) else $error("keep");
	a_gap_hold: assert property (!ld & !bus_reset_i |=> $stable(gap_count_o)) else $error("hold");
endmodule // sbr_gap_ctrl_monitor
bind sbr_gap_ctrl sbr_gap_ctrl_monitor u_mon(.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg1_wr_i(reg1_wr_i),
	.cfg_rx_i(cfg_rx_i), .cfg_tx_i(cfg_tx_i), .cfg_rhf_i(cfg_rhf_i), .bus_reset_i(bus_reset_i),
	.root_holdoff_flag_o(root_holdoff_flag_o), .bus_reset_req_o(bus_reset_req_o), .reg1_wdata_i(reg1_wdata_i),
	.reg1_rdata_o(reg1_rdata_o), .cfg_gap_i(cfg_gap_i), .gap_count_o(gap_count_o));

// *** bench/sbr_node_model.sv ***
// far-side node model: requests, sent packets and new links cause bus resets
`timescale 1ns/1ps
module sbr_node_model(input wire core_clk_i, req_i, tx_i, conn_i, output reg rst_o = 1'b0);
	always @(posedge core_clk_i) rst_o <= req_i | tx_i | conn_i;
endmodule // sbr_node_model

// *** hdl/sbr_gap_ctrl.v ***
// bus-reset request and gap-count / root-holdoff management for a serial bus phy
// Behaviour
// R1 - a write with the bus-reset request bit at one starts a bus reset and the initialization sequence.
// R2 - every write of phy register 1 loads root-holdoff and gap count together with the request bit.
// R3 - root-holdoff and gap count are loaded from phy-config packets both received and transmitted.
// R4 - gap count is forced to 63 after two consecutive bus resets with no gap-count update between.
// R5 - a reset requested by the register write keeps the just-written gap count locally.
// R6 - the controlling party always follows a sent phy-config packet with a bus reset.
// R7 - a follow-up reset by register must rewrite the values of the sent packet, readable back from register 1.
// R8 - any other register reset writes gap count 63 and keeps the current root-holdoff value.
// R9 - software writes register 1 only when setting the request bit.
// R10 - gap count is a six-bit field and a reset counter is cleared by every gap-count load.
`timescale 1ns/1ps
`include "sbr_consts.vh"
module sbr_gap_ctrl #(
	parameter GAP_W = `SBR_GAP_W
) (
	input wire core_clk_i,
	input wire nrst_i,
	input wire reg1_wr_i,
	input wire [`SBR_REG1_W-1:0] reg1_wdata_i,
	input wire cfg_rx_i,
	input wire cfg_tx_i,
	input wire cfg_rhf_i,
	input wire [GAP_W-1:0] cfg_gap_i,
	input wire bus_reset_i,
	output wire [`SBR_REG1_W-1:0] reg1_rdata_o,
	output wire [GAP_W-1:0] gap_count_o,
	output wire root_holdoff_flag_o,
	output reg bus_reset_req_o
);
	reg [GAP_W-1:0] gap_q;
	reg [GAP_W-1:0] gap_d;
	reg rhf_q;
	reg rhf_d;
	reg bus_reset_request_bit_q;
	reg skip_q;
	reg skip_d;
	wire wr_req;
	wire cfg_load;
	wire gap_update;
	wire force_max;
	wire reset_seen;

	assign wr_req = reg1_wr_i && reg1_wdata_i[`SBR_REG1_REQ_BIT]; // [R1]
	assign cfg_load = cfg_rx_i || cfg_tx_i; // [R3]
	assign gap_update = reg1_wr_i || cfg_load; // [R10]
	// the reset requested by a register write does not count toward the force
	assign reset_seen = bus_reset_i && !skip_q; // [R5]

	sbr_reset_cnt u_cnt (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.bus_reset_i(reset_seen),
		.gap_update_i(gap_update),
		.force_o(force_max)
	);

	always @* begin
		gap_d = gap_q;
		rhf_d = rhf_q;
		skip_d = skip_q;
		if (bus_reset_i) begin
			skip_d = 1'b0;
		end
		if (force_max) begin
			gap_d = `SBR_GAP_MAX; // [R4]
		end
		if (cfg_load) begin
			gap_d = cfg_gap_i; // [R3]
			rhf_d = cfg_rhf_i; // [R3]
		end
		if (reg1_wr_i) begin
			gap_d = reg1_wdata_i[`SBR_REG1_GAP_LSB +: GAP_W]; // [R2]
			rhf_d = reg1_wdata_i[`SBR_REG1_RHF_BIT]; // [R2]
			skip_d = wr_req; // [R5]
		end
	end

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gap_q <= `SBR_GAP_RST;
			rhf_q <= `SBR_RHF_RST;
			skip_q <= 1'b0;
			bus_reset_request_bit_q <= 1'b0;
			bus_reset_req_o <= 1'b0;
		end else begin
			gap_q <= gap_d;
			rhf_q <= rhf_d;
			skip_q <= skip_d;
			bus_reset_request_bit_q <= wr_req;
			bus_reset_req_o <= wr_req; // [R1]
		end
	end

	// register 1 read back so software can rewrite the loaded values
	assign reg1_rdata_o = {rhf_q, bus_reset_request_bit_q, gap_q}; // [R7]
	assign gap_count_o = gap_q;
	assign root_holdoff_flag_o = rhf_q;
endmodule // sbr_gap_ctrl

// *** hdl/sbr_reset_cnt.v ***
// consecutive bus reset counter that flags when the gap count must be forced
`timescale 1ns/1ps
`include "sbr_consts.vh"
module sbr_reset_cnt #(
	parameter CNT_W = `SBR_RST_CNT_W,
	parameter [CNT_W-1:0] LIMIT = `SBR_RST_LIMIT
) (
	input wire core_clk_i,
	input wire nrst_i,
	input wire bus_reset_i,
	input wire gap_update_i,
	output wire force_o
);
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;

	// force fires on the reset that reaches the limit
	assign force_o = bus_reset_i && !gap_update_i && (cnt_q == LIMIT - {{(CNT_W-1){1'b0}}, 1'b1});

	always @* begin
		cnt_d = cnt_q;
		if (gap_update_i) begin
			cnt_d = {CNT_W{1'b0}}; // [R10]
		end else if (bus_reset_i && cnt_q != LIMIT) begin
			cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // [R10]
		end
	end

	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= {CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule // sbr_reset_cnt

// *** include/sbr_consts.vh ***
// constants for the bus-reset and gap-count control block
`ifndef SBR_CONSTS_VH
`define SBR_CONSTS_VH
`define SBR_GAP_W 6
`define SBR_GAP_MAX 6'h3f
`define SBR_GAP_RST 6'h3f
`define SBR_RHF_RST 1'b0
`define SBR_RST_CNT_W 2
`define SBR_RST_LIMIT 2'h2
`define SBR_REG1_REQ_BIT 6
`define SBR_REG1_RHF_BIT 7
`define SBR_REG1_GAP_LSB 0
`define SBR_REG1_W 8
`endif
